/* core/srxoc_map.svh */
// register offsets, field positions, reset values and counts of the receiver output control
// assumes a 32-bit apb slave with byte addresses and aligned words
`ifndef SRXOC_MAP_SVH
`define SRXOC_MAP_SVH
`define SRXOC_OFF_STATUS 12'h000
`define SRXOC_OFF_IRQ_STAT 12'h004
`define SRXOC_OFF_IRQ_MASK 12'h008
`define SRXOC_OFF_CTRL 12'h00c
`define SRXOC_STAT_LOCKED 0
`define SRXOC_STAT_SLEEP 1
`define SRXOC_STAT_REF_OK 2
`define SRXOC_STAT_OUT_EN 3
`define SRXOC_IRQ_LOCK_GAIN 0
`define SRXOC_IRQ_LOCK_LOSS 1
`define SRXOC_IRQ_FRAME_ERR 2
`define SRXOC_IRQ_SLEEP 3
`define SRXOC_IRQ_W 4
`define SRXOC_CTRL_RELOCK 0
`define SRXOC_RST_IRQ_MASK 4'h0
`define SRXOC_RST_IRQ_STAT 4'h0
`define SRXOC_DATA_W 10
`define SRXOC_SYNC_WORD 10'h01f
`define SRXOC_SYNC_COUNT 16
`define SRXOC_REF_TIMEOUT 64
`define SRXOC_PIN_IDLE 6'h18
`endif

/* core/srxoc_pkg.sv */
// types shared by the receiver output control
// assumes srxoc_map.svh supplies the numeric constants
package srxoc_pkg;
	// one-hot link states
	typedef enum logic [2:0] {
		st_sleep = 3'b001,
		st_hunt = 3'b010,
		st_lock = 3'b100
	} srxoc_state_e;
endpackage : srxoc_pkg

/* core/srxoc_top.sv */
// receiver output control: frame lock, recovered clock, gated parallel outputs, apb status
// assumes one 125 MHz clock; serial bits arrive one per clock on the differential pair pins;
// the pads resolve each pin from its output and enable signals
//
// Functional notes
// [RULE1] edge select high strobes data on rising recovered clock, low on falling
// [RULE2] sleep request low stops lock, floats every output regardless of output enable
// [RULE3] lock indicator goes low once locked, stays high while unlocked
// [RULE4] recovered clock runs at word rate from embedded frame edges, strobes each word
// [RULE5] output enable low floats all data outputs and recovered clock
// [RULE6] while unlocked, data and recovered clock stay floating even if enabled
// [RULE7] while awake, lock indicator is always driven, even with output enable low
// [RULE8] recovered clock runs only locked and enabled; then data and clock are active
// [RULE9] outside supplies a reference clock that the lock logic relies on
// [RULE10] transmitter sends at least 1024 sync symbols while its sync request is high
// [RULE11] after power-up, until first lock, indicator high and outputs floating
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "srxoc_map.svh"

module srxoc_top
	import srxoc_pkg::*;
#(
	parameter int DATA_W = `SRXOC_DATA_W,
	parameter int SYNC_COUNT = `SRXOC_SYNC_COUNT,
	parameter int REF_TIMEOUT = `SRXOC_REF_TIMEOUT
) (
	input wire logic clock,
	input wire logic rst_n,
	// pins
	input wire logic serial_in_pos,
	input wire logic serial_in_neg,
	input wire logic recovered_clock_edge_select,
	input wire logic sleep_request_n,
	input wire logic output_enable_n,
	input wire logic pll_reference_clock,
	output logic [DATA_W-1:0] parallel_data_out,
	output logic parallel_data_oe,
	output logic recovered_clock_out,
	output logic recovered_clock_oe,
	output logic lock_n_out,
	output logic lock_n_oe,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	localparam int FRAME_LEN = DATA_W + 2;
	localparam int PH_W = $clog2(FRAME_LEN);
	localparam int SC_W = $clog2(SYNC_COUNT + 1);
	localparam int RC_W = $clog2(REF_TIMEOUT + 1);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(FRAME_LEN - 1);
	localparam logic [PH_W-1:0] PH_HALF = PH_W'(FRAME_LEN / 2);
	localparam logic [SC_W-1:0] SC_DONE = SC_W'(SYNC_COUNT);
	localparam logic [RC_W-1:0] RC_MAX = RC_W'(REF_TIMEOUT);
	localparam logic [DATA_W-1:0] SYNC_WORD = DATA_W'(`SRXOC_SYNC_WORD);

	// refuse sizes the framing and the 32-bit register view cannot hold
	generate
		if (DATA_W < 2 || DATA_W > 30 || SYNC_COUNT < 1 || REF_TIMEOUT < 2) begin : g_bad
			$error("srxoc_top: unsupported parameter values");
		end
	endgenerate

	// register address decode, shared by read and write paths
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `SRXOC_OFF_STATUS) || (a == `SRXOC_OFF_IRQ_STAT) ||
			(a == `SRXOC_OFF_IRQ_MASK) || (a == `SRXOC_OFF_CTRL);
	endfunction : is_mapped

	// two-stage synchronisers for every pin input; stage one feeds stage two only
	localparam int NPIN = 6;
	localparam logic [NPIN-1:0] PIN_IDLE = `SRXOC_PIN_IDLE;
	logic [NPIN-1:0] pin_sync_r;
	logic [NPIN-1:0] pin_raw;
	assign pin_raw = {pll_reference_clock, output_enable_n, sleep_request_n,
		recovered_clock_edge_select, serial_in_neg, serial_in_pos};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic meta_r;
			logic sync_r;
			// reset to the idle pin level, so no false sleep follows reset
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					meta_r <= PIN_IDLE[gi];
					sync_r <= PIN_IDLE[gi];
				end else begin
					meta_r <= pin_raw[gi];
					sync_r <= meta_r;
				end
			end
			assign pin_sync_r[gi] = sync_r;
		end
	endgenerate

	logic ser_bit;
	logic edge_sel;
	logic sleep_req;
	logic out_en;
	logic ref_lvl;
	assign ser_bit = pin_sync_r[0] & ~pin_sync_r[1]; // differential decision
	assign edge_sel = pin_sync_r[2];
	assign sleep_req = ~pin_sync_r[3];
	assign out_en = pin_sync_r[4]; // enable pin high drives, low floats
	assign ref_lvl = pin_sync_r[5];

	// link state
	srxoc_state_e state_r, state_nxt;
	logic [FRAME_LEN-1:0] frame_r, frame_nxt;
	logic [PH_W-1:0] phase_r, phase_nxt;
	logic [SC_W-1:0] sync_cnt_r, sync_cnt_nxt;
	logic [RC_W-1:0] ref_cnt_r, ref_cnt_nxt;
	logic ref_prev_r, ref_prev_nxt;
	logic [DATA_W-1:0] word_r, word_nxt;
	logic [DATA_W-1:0] data_r, data_nxt;
	logic rclk_r, rclk_nxt;
	logic lock_n_r, lock_n_nxt;
	logic ev_gain, ev_loss, ev_ferr, ev_sleep;
	logic relock_req;
	logic ref_ok;
	logic frame_good;
	logic sync_seen;
	logic locked_nxt;

	assign ref_ok = (ref_cnt_r < RC_MAX); // reference seen toggling lately
	// a frame is start one, payload, stop zero; the one-to-zero pair is the embedded edge
	assign frame_good = frame_r[FRAME_LEN-1] & ~frame_r[0];
	assign sync_seen = frame_good && (frame_r[FRAME_LEN-2:1] == SYNC_WORD);

	// next-state logic of lock, framing, recovered clock and data strobing
	always_comb begin
		state_nxt = state_r;
		frame_nxt = {frame_r[FRAME_LEN-2:0], ser_bit};
		phase_nxt = (phase_r == PH_LAST) ? '0 : phase_r + 1'b1;
		sync_cnt_nxt = sync_cnt_r;
		ref_prev_nxt = ref_lvl;
		ref_cnt_nxt = (ref_lvl != ref_prev_r) ? '0 :
			(ref_ok ? ref_cnt_r + 1'b1 : ref_cnt_r);
		word_nxt = word_r;
		data_nxt = data_r;
		ev_gain = 1'b0;
		ev_loss = 1'b0;
		ev_ferr = 1'b0;
		ev_sleep = 1'b0;
		unique case (state_r)
			st_sleep: begin
				sync_cnt_nxt = '0;
				if (!sleep_req) begin
					state_nxt = st_hunt;
				end
			end
			st_hunt: begin
				// count sync symbols that repeat exactly one frame apart
				if (sync_seen) begin
					phase_nxt = '0;
					sync_cnt_nxt = (phase_r == PH_LAST && sync_cnt_r != '0) ?
						sync_cnt_r + 1'b1 : SC_W'(1);
				end else if (phase_r == PH_LAST) begin
					sync_cnt_nxt = '0;
				end
				if (sync_seen && sync_cnt_nxt >= SC_DONE && ref_ok) begin // RULE9
					state_nxt = st_lock; // RULE3
					ev_gain = 1'b1;
					word_nxt = frame_r[FRAME_LEN-2:1];
				end
			end
			st_lock: begin
				// check the embedded edge at every frame boundary
				if (phase_r == PH_LAST) begin
					if (frame_good) begin
						word_nxt = frame_r[FRAME_LEN-2:1];
					end else begin
						ev_ferr = 1'b1;
					end
				end
				if (ev_ferr || !ref_ok || relock_req) begin // RULE9
					state_nxt = st_hunt; // RULE3
					sync_cnt_nxt = '0;
					ev_loss = 1'b1;
				end
			end
		endcase
		// sleep wins over every other transition
		if (sleep_req) begin
			ev_gain = 1'b0; // a lock overridden by sleep is never reported
			if (state_r != st_sleep) begin
				ev_sleep = 1'b1;
				ev_loss = state_r == st_lock;
			end
			state_nxt = st_sleep; // RULE2
			sync_cnt_nxt = '0;
		end
		locked_nxt = (state_nxt == st_lock);
		lock_n_nxt = ~locked_nxt; // RULE3 RULE11
		// recovered clock: high for the first half frame, rising as each word completes
		rclk_nxt = locked_nxt && (phase_nxt < PH_HALF); // RULE4 RULE8
		// change data half a word away from the selected strobe edge
		if (locked_nxt) begin
			if (edge_sel && phase_nxt == PH_HALF) begin
				data_nxt = word_nxt; // RULE1
			end else if (!edge_sel && phase_nxt == '0) begin
				data_nxt = word_nxt; // RULE1
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= st_hunt;
			frame_r <= '0;
			phase_r <= '0;
			sync_cnt_r <= '0;
			ref_cnt_r <= '0;
			ref_prev_r <= 1'b0;
			word_r <= '0;
			data_r <= '0;
			rclk_r <= 1'b0;
			lock_n_r <= 1'b1; // RULE11
		end else begin
			state_r <= state_nxt;
			frame_r <= frame_nxt;
			phase_r <= phase_nxt;
			sync_cnt_r <= sync_cnt_nxt;
			ref_cnt_r <= ref_cnt_nxt;
			ref_prev_r <= ref_prev_nxt;
			word_r <= word_nxt;
			data_r <= data_nxt;
			rclk_r <= rclk_nxt;
			lock_n_r <= lock_n_nxt;
		end
	end

	// pad drive: the lock pin floats only in sleep; data and clock need lock and enable
	logic awake;
	logic par_drive;
	assign awake = (state_r != st_sleep);
	assign par_drive = awake && out_en && !lock_n_r; // RULE2 RULE5 RULE6 RULE8 RULE11
	assign parallel_data_out = data_r;
	assign parallel_data_oe = par_drive;
	assign recovered_clock_out = rclk_r;
	assign recovered_clock_oe = par_drive;
	assign lock_n_out = lock_n_r;
	assign lock_n_oe = awake; // RULE2 RULE7

	// apb registers: zero wait states, read data captured in the setup cycle
	logic [`SRXOC_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
	logic [`SRXOC_IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
	logic relock_r, relock_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic wr_en;
	logic [`SRXOC_IRQ_W-1:0] ev_vec;
	logic [`SRXOC_IRQ_W-1:0] w1c;

	assign wr_en = psel && penable && pwrite && is_mapped(paddr) && pstrb[0];
	assign relock_req = relock_r;
	always_comb begin
		ev_vec = '0;
		ev_vec[`SRXOC_IRQ_LOCK_GAIN] = ev_gain;
		ev_vec[`SRXOC_IRQ_LOCK_LOSS] = ev_loss;
		ev_vec[`SRXOC_IRQ_FRAME_ERR] = ev_ferr;
		ev_vec[`SRXOC_IRQ_SLEEP] = ev_sleep;
		w1c = '0;
		irq_mask_nxt = irq_mask_r;
		relock_nxt = 1'b0; // self-clearing request
		prdata_nxt = prdata_r;
		if (wr_en && paddr == `SRXOC_OFF_IRQ_STAT) begin
			w1c = pwdata[`SRXOC_IRQ_W-1:0];
		end
		if (wr_en && paddr == `SRXOC_OFF_IRQ_MASK) begin
			irq_mask_nxt = pwdata[`SRXOC_IRQ_W-1:0];
		end
		if (wr_en && paddr == `SRXOC_OFF_CTRL) begin
			relock_nxt = pwdata[`SRXOC_CTRL_RELOCK];
		end
		// a new event beats a clear in the same cycle
		irq_stat_nxt = (irq_stat_r & ~w1c) | ev_vec;
		if (psel && !penable && !pwrite) begin
			prdata_nxt = 32'h0000_0000;
			if (paddr == `SRXOC_OFF_STATUS) begin
				prdata_nxt[`SRXOC_STAT_LOCKED] = !lock_n_r;
				prdata_nxt[`SRXOC_STAT_SLEEP] = !awake;
				prdata_nxt[`SRXOC_STAT_REF_OK] = ref_ok;
				prdata_nxt[`SRXOC_STAT_OUT_EN] = out_en;
			end else if (paddr == `SRXOC_OFF_IRQ_STAT) begin
				prdata_nxt[`SRXOC_IRQ_W-1:0] = irq_stat_r;
			end else if (paddr == `SRXOC_OFF_IRQ_MASK) begin
				prdata_nxt[`SRXOC_IRQ_W-1:0] = irq_mask_r;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_stat_r <= `SRXOC_RST_IRQ_STAT;
			irq_mask_r <= `SRXOC_RST_IRQ_MASK;
			relock_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			relock_r <= relock_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1; // every access completes in its first access cycle
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign irq = |(irq_stat_r & irq_mask_r);
endmodule : srxoc_top

/* test/srxoc_ser_model.sv */
// serializer model: framed words on the pair and a reference clock
// assumes one bit per clock; frame is start 1, ten bits msb first, stop
`timescale 1ns/1ns
`include "srxoc_map.svh"

module srxoc_ser_model #(
	parameter int MIN_SYNC = 1024
) (
	input wire logic clock,
	input wire logic sync_req,
	input wire logic bad_stop,
	input wire logic [9:0] word,
	output logic serial_in_pos,
	output logic serial_in_neg,
	output logic pll_reference_clock
);
	logic ref_r = 1'b0;
	logic [11:0] frame_r = 12'h000;
	logic [3:0] bit_r = 4'h0;
	logic [10:0] left_r = 11'h000;
	logic [1:0] div_r = 2'h0;
	// the pair is always driven, bit and inverse
	assign serial_in_pos = frame_r[11];
	assign serial_in_neg = ~frame_r[11];
	assign pll_reference_clock = ref_r;
	// reference runs slower than half the clock so it can be seen
	always @(posedge clock) begin
		div_r <= div_r + 2'h1;
		if (div_r == 2'h3) ref_r <= ~ref_r;
	end
	// sync symbols go on for the minimum count after the request drops
	always @(posedge clock) begin
		if (bit_r == 4'hb) begin
			bit_r <= 4'h0;
			frame_r <= {1'b1, (sync_req || left_r != 0) ? `SRXOC_SYNC_WORD : word, bad_stop};
			left_r <= sync_req ? 11'(MIN_SYNC) : left_r - 11'(left_r != 0);
		end else begin
			bit_r <= bit_r + 4'h1;
			frame_r <= {frame_r[10:0], 1'b0};
		end
	end
endmodule : srxoc_ser_model

/* test/srxoc_top_asserts.sv */
// pin checks of the receiver output control
// assumes it is bound into srxoc_top and that all pins are sampled on the rising clock
`timescale 1ns/1ns

module srxoc_top_chk #(
	parameter int DATA_W = 10
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic recovered_clock_edge_select,
	input wire logic sleep_request_n,
	input wire logic output_enable_n,
	input wire logic [DATA_W-1:0] parallel_data_out,
	input wire logic parallel_data_oe,
	input wire logic recovered_clock_out,
	input wire logic recovered_clock_oe,
	input wire logic lock_n_out,
	input wire logic lock_n_oe
);
	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// a word move while lock is steady; with edge select low the first word, moved as lock falls, is left out
	sequence s_move;
		$changed(parallel_data_out) && !lock_n_out && $stable(lock_n_out);
	endsequence
	// six high, six low, then high again
	sequence s_period;
		recovered_clock_out[*6] ##1 !recovered_clock_out[*6] ##1 recovered_clock_out;
	endsequence
	property p_edge_rise;
		recovered_clock_edge_select[*4] ##0 s_move |-> $fell(recovered_clock_out);
	endproperty
	a_edge_rise: assert property (p_edge_rise) else $error("word moved off falling edge");
	property p_edge_fall;
		!recovered_clock_edge_select[*4] ##0 s_move |-> $rose(recovered_clock_out);
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("word moved off rising edge");
	// synchroniser delay is why the low level must last a few cycles first
	property p_sleep;
		!sleep_request_n[*5] |-> !lock_n_oe && !parallel_data_oe && !recovered_clock_oe;
	endproperty
	a_sleep: assert property (p_sleep) else $error("pin driven while asleep");
	property p_period;
		disable iff (!rst_n || lock_n_out || !sleep_request_n)
		$rose(recovered_clock_out) |-> s_period;
	endproperty
	a_period: assert property (p_period) else $error("recovered clock not word rate");
	property p_disabled;
		(output_enable_n == 1'b0)[*4] |-> !parallel_data_oe && !recovered_clock_oe;
	endproperty
	a_disabled: assert property (p_disabled) else $error("outputs driven while disabled");
	property p_unlocked;
		lock_n_out |-> !parallel_data_oe && !recovered_clock_oe;
	endproperty
	a_unlocked: assert property (p_unlocked) else $error("outputs driven while unlocked");
	property p_awake;
		sleep_request_n[*8] |-> lock_n_oe;
	endproperty
	a_awake: assert property (p_awake) else $error("lock pin floats while awake");
	property p_active;
		(sleep_request_n && output_enable_n)[*5] ##0 !lock_n_out |-> parallel_data_oe && recovered_clock_oe;
	endproperty
	a_active: assert property (p_active) else $error("outputs float while locked");
endmodule : srxoc_top_chk

bind srxoc_top srxoc_top_chk #(.DATA_W(DATA_W)) u_srxoc_top_chk (.clock, .rst_n,
	.recovered_clock_edge_select, .sleep_request_n, .output_enable_n, .parallel_data_out,
	.parallel_data_oe, .recovered_clock_out, .recovered_clock_oe, .lock_n_out, .lock_n_oe);

/* test/srxoc_top_tb.sv */
// bench of the receiver output control: apb accesses and link traffic
// assumes the design, the serializer model and the checker are compiled first
`timescale 1ns/1ns
`include "srxoc_map.svh"

module srxoc_top_tb;
	logic clock = 1'b0, rst_n = 1'b0, sync_req = 1'b1, bad_stop = 1'b0;
	logic recovered_clock_edge_select = 1'b1, sleep_request_n = 1'b1, output_enable_n = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0] pstrb = 4'hf;
	logic [9:0] word = 10'h2a5, parallel_data_out;
	logic serial_in_pos, serial_in_neg, pll_reference_clock, parallel_data_oe, pready;
	logic recovered_clock_out, recovered_clock_oe, lock_n_out, lock_n_oe, pslverr, irq;
	int fail_count = 0, total_checks = 0, i;
	srxoc_ser_model u_srxoc_ser_model (.clock, .sync_req, .bad_stop, .word, .serial_in_pos,
		.serial_in_neg, .pll_reference_clock);
	srxoc_top u_srxoc_top (.clock, .rst_n, .serial_in_pos, .serial_in_neg,
		.recovered_clock_edge_select, .sleep_request_n, .output_enable_n, .pll_reference_clock,
		.parallel_data_out, .parallel_data_oe, .recovered_clock_out, .recovered_clock_oe,
		.lock_n_out, .lock_n_oe, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .irq);
	// free running clock
	initial begin
		forever #4 clock = ~clock;
	end
	// a run should end near 13k cycles
	initial begin
		#(40000 * 8);
		fail_count++;
		report_and_stop();
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// request held until pready is seen; entered just after a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task wait_lock(input logic v);
		for (i = 0; i < 30000 && lock_n_out !== v; i++) @(posedge clock);
	endtask : wait_lock
	task wait_word;
		for (i = 0; i < 30000 && parallel_data_out !== word; i++) @(posedge clock);
	endtask : wait_word
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk("lock_n_out", 1, lock_n_out);
		chk("data_oe", 0, parallel_data_oe);
		apb(1'b0, `SRXOC_OFF_IRQ_MASK, 0);
		chk("irq_mask", 0, q);
		apb(1'b0, 12'h010, 0);
		chk("pslverr", 1, e);
		apb(1'b1, `SRXOC_OFF_IRQ_MASK, 32'hf);
		apb(1'b1, `SRXOC_OFF_IRQ_STAT, 32'hf);
		chk("irq", 0, irq);
		wait_lock(1'b0);
		chk("lock_n_out", 0, lock_n_out);
		apb(1'b0, `SRXOC_OFF_STATUS, 0);
		chk("locked", 1, q[0]);
		chk("status", 4'hd, q[3:0]);
		chk("irq", 1, irq);
		chk("data_oe", 1, parallel_data_oe);
		apb(1'b1, `SRXOC_OFF_IRQ_STAT, 32'hf);
		chk("irq", 0, irq);
		sync_req <= 1'b0;
		wait_word();
		chk("data", word, parallel_data_out);
		recovered_clock_edge_select <= 1'b0;
		word <= 10'h15a;
		@(posedge clock);
		wait_word();
		chk("data", 10'h15a, parallel_data_out);
		output_enable_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk("clock_oe", 0, recovered_clock_oe);
		chk("lock_n_oe", 1, lock_n_oe);
		output_enable_n <= 1'b1;
		bad_stop <= 1'b1;
		wait_lock(1'b1);
		bad_stop <= 1'b0;
		chk("data_oe", 0, parallel_data_oe);
		apb(1'b0, `SRXOC_OFF_IRQ_STAT, 0);
		chk("irq_stat", 4'h6, q[3:0]);
		sleep_request_n <= 1'b0;
		repeat (6) @(posedge clock);
		chk("lock_n_oe", 0, lock_n_oe);
		apb(1'b0, `SRXOC_OFF_STATUS, 0);
		chk("sleep", 1, q[1]);
		// wake, lock again, then drop lock on request
		sleep_request_n <= 1'b1;
		sync_req <= 1'b1;
		wait_lock(1'b0);
		chk("lock_n_out", 0, lock_n_out);
		apb(1'b1, `SRXOC_OFF_IRQ_STAT, 32'hf);
		apb(1'b1, `SRXOC_OFF_CTRL, 32'h1);
		apb(1'b0, `SRXOC_OFF_IRQ_STAT, 0);
		chk("irq_stat", 4'h2, q[3:0]);
		chk("lock_n_out", 1, lock_n_out);
		report_and_stop();
	end
endmodule : srxoc_top_tb
